// >>> hw/crf_map.svh
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

// core register offsets seen by the debug module
`define CRF_OFF_ACC 8'h00
`define CRF_OFF_PCE 8'h01
`define CRF_OFF_PCH 8'h02
`define CRF_OFF_PCL 8'h03
`define CRF_OFF_XH 8'h04
`define CRF_OFF_XL 8'h05
`define CRF_OFF_YH 8'h06
`define CRF_OFF_YL 8'h07
`define CRF_OFF_SPH 8'h08
`define CRF_OFF_SPL 8'h09
`define CRF_OFF_CC 8'h0a
// global configuration offset in its own space
`define CRF_OFF_GCR 8'h00

// condition flag bit positions
`define CRF_CC_C 0
`define CRF_CC_Z 1
`define CRF_CC_N 2
`define CRF_CC_I0 3
`define CRF_CC_H 4
`define CRF_CC_I1 5
`define CRF_CC_RSV 6
`define CRF_CC_V 7
`define CRF_CC_MASK 8'hbf

// global configuration bits
`define CRF_GCR_SWD 0
`define CRF_GCR_AL 1
`define CRF_GCR_MASK 8'h03

// reset values
`define CRF_GCR_RST 8'h00
`define CRF_CC_RST 8'h28
`define CRF_DATA_RST 8'h00

// stack byte counts
`define CRF_IRQ_BYTES 4'd9
`define CRF_CALL_NEAR 4'd2
`define CRF_CALL_FAR 4'd3

`endif

// >>> hw/crf_pkg.sv
package crf_pkg;

  typedef enum logic [4:0] {
    CRF_OP_NONE, CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_SBC, CRF_OP_CP,
    CRF_OP_INC, CRF_OP_DEC, CRF_OP_NEG, CRF_OP_LOGIC, CRF_OP_LOAD,
    CRF_OP_SHIFT, CRF_OP_BTJ, CRF_OP_DIV, CRF_OP_SCF, CRF_OP_RCF,
    CRF_OP_CCF, CRF_OP_SIM, CRF_OP_RIM
  } crf_op_t;

  typedef enum logic [1:0] {CRF_ST_IDLE, CRF_ST_PUSH, CRF_ST_POP} crf_state_t;

  typedef enum logic [1:0] {CRF_K_CALL, CRF_K_IRQ, CRF_K_WFI} crf_kind_t;

  // register access from the debug module or the configuration space
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crf_acc_req_t;

  // per-cycle requests from the execution unit
  typedef struct packed {
    crf_op_t op;
    logic [7:0] opnd;
    logic aux;
    logic idx_wr;
    logic [15:0] idx_data;
    logic prefix;
    logic instr_end;
    logic [23:0] pc_next;
    logic call;
    logic call_far;
    logic ret;
    logic ret_far;
    logic [23:0] target;
    logic wait_for_interrupt_op;
    logic interrupt_return_op;
    logic irq;
    logic [23:0] vector;
  } crf_exec_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crf_stack_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] x;
    logic [15:0] y;
    logic [23:0] pc;
    logic [15:0] sp;
    logic [7:0] cc;
  } crf_view_t;

endpackage : crf_pkg

// >>> hw/crf_core.sv
`timescale 1ns/10ps
`include "crf_map.svh"
// Overview of operation
// - interrupt entry pushes context in fixed order; return pops exactly reversed.
// - eight-bit accumulator holds operands and results of data operations.
// - two sixteen-bit index registers for addressing, storage, multiply, divide.
// - a prefix makes the next instruction use the second index register.
// - 24-bit program counter updated after each instruction, 16 Mbyte space.
// - stack pointer marks next free byte; upper bits may be forced.
// - pointer decrements per pushed byte, increments per popped byte, unguarded.
// - calls push two or three bytes; interrupts push nine, not SP.
// - wait or halt stacks context early so interrupts enter faster.
// - flag bit 6 is reserved and reads zero.
// - overflow flag reports signed overflow of arithmetic results.
// - mask bits: 10 main, 01 level 1, 00 level 2, 11 masked.
// - both mask bits set on interrupt entry; instructions may change them.
// - half carry reports carry from bit 3 to 4 on add.
// - negative flag copies result most significant bit.
// - zero flag set when result is zero, cleared otherwise.
// - carry catches arithmetic carry or borrow, shifts, set, clear, toggle.
// - divide sets carry on quotient overflow or zero divisor.
// - bit test and branch copies the tested bit into carry.
// - core registers at offsets 0x00 to 0x0a, debug module only.
// - activation bit 0 restores context on return; 1 goes back to sleep.
// - debug link owns its pin after reset until the disable bit is set.
module crf_core #(
  parameter logic [15:0] SP_FORCE_MASK = 16'h0000,
  parameter logic [15:0] SP_FORCE_VAL = 16'h0000,
  parameter logic [15:0] SP_RST = 16'h03ff
) (
  input wire logic clock,
  input wire logic nrst,
  input wire crf_pkg::crf_acc_req_t dbg,
  output logic [7:0] dbg_rdata,
  input wire crf_pkg::crf_acc_req_t cfg,
  output logic [7:0] cfg_rdata,
  input wire crf_pkg::crf_exec_t exe,
  output crf_pkg::crf_stack_t stk,
  input wire logic [7:0] stk_rdata,
  output crf_pkg::crf_view_t view,
  output logic busy,
  output logic sleeping,
  output logic ctx_saved,
  output logic link_en,
  output logic pin_gpio
);
  import crf_pkg::*;

  logic [7:0] acc;
  logic [15:0] x;
  logic [15:0] y;
  logic [23:0] pc;
  logic [15:0] sp;
  logic [7:0] cc;
  logic [7:0] gcr;
  logic prefix_y;
  crf_state_t state;
  crf_kind_t kind;
  logic [3:0] cnt;
  logic [3:0] len;
  logic [23:0] target;

  // forced upper stack pointer bits apply to every write
  function automatic logic [15:0] sp_fix(input logic [15:0] v);
    sp_fix = (v & ~SP_FORCE_MASK) | (SP_FORCE_VAL & SP_FORCE_MASK);
  endfunction : sp_fix

  // {carry, half, overflow, result}; sub uses add of inverted operand
  function automatic logic [10:0] alu8(input logic [7:0] a,
      input logic [7:0] b, input logic cin, input logic sub);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] lo;
    logic cy;
    bb = sub ? ~b : b;
    cy = sub ? ~cin : cin;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, cy};
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cy};
    alu8 = {s[8] ^ sub, lo[4], (a[7] == bb[7]) && (s[7] != a[7]), s[7:0]};
  endfunction : alu8

  // context byte for a stack slot; slot 0 is pushed first
  function automatic logic [7:0] ctx_byte(input logic [3:0] i,
      input crf_view_t v);
    unique case (i)
      4'd0: ctx_byte = v.pc[7:0];
      4'd1: ctx_byte = v.pc[15:8];
      4'd2: ctx_byte = v.pc[23:16];
      4'd3: ctx_byte = v.y[7:0];
      4'd4: ctx_byte = v.y[15:8];
      4'd5: ctx_byte = v.x[7:0];
      4'd6: ctx_byte = v.x[15:8];
      4'd7: ctx_byte = v.acc;
      default: ctx_byte = v.cc;
    endcase
  endfunction : ctx_byte

  // request decode, all but debug writes taken only while idle
  logic idle;
  logic dwr;
  logic start_irq;
  logic skip_irq;
  logic start_wfi;
  logic start_call;
  logic start_pop;
  logic sleep_interrupt_return_op;
  logic push_done;
  logic pop_now;
  logic alu_go;
  logic [10:0] alu;
  assign idle = (state == CRF_ST_IDLE);
  assign dwr = dbg.sel && dbg.wr;
  assign skip_irq = idle && exe.irq && ctx_saved;
  assign start_irq = idle && exe.irq && !ctx_saved;
  assign start_wfi = idle && !exe.irq && exe.wait_for_interrupt_op && !ctx_saved;
  assign start_call = idle && !exe.irq && !exe.wait_for_interrupt_op && exe.call;
  assign start_pop = idle && !exe.irq && !exe.wait_for_interrupt_op && !exe.call &&
                     (exe.ret || (exe.interrupt_return_op && !gcr[`CRF_GCR_AL]));
  assign sleep_interrupt_return_op = idle && !exe.irq && !exe.wait_for_interrupt_op && !exe.call &&
                      !exe.ret && exe.interrupt_return_op && gcr[`CRF_GCR_AL];
  assign push_done = (state == CRF_ST_PUSH) && (cnt == len - 4'd1);
  assign pop_now = (state == CRF_ST_POP);
  assign alu_go = idle && (exe.op != CRF_OP_NONE);
  assign busy = !idle;

  // the view is the architectural state as flip-flops
  assign view = '{acc: acc, x: x, y: y, pc: pc, sp: sp, cc: cc};

  // stack sequencer: push counts slots up, pop counts them down
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= CRF_ST_IDLE;
      kind <= CRF_K_CALL;
      cnt <= 4'd0;
      len <= 4'd0;
    end else begin
      unique case (state)
        CRF_ST_IDLE: begin
          if (start_irq || start_wfi) begin
            state <= CRF_ST_PUSH;
            kind <= start_irq ? CRF_K_IRQ : CRF_K_WFI;
            cnt <= 4'd0;
            len <= `CRF_IRQ_BYTES;
          end else if (start_call) begin
            state <= CRF_ST_PUSH;
            kind <= CRF_K_CALL;
            cnt <= 4'd0;
            len <= exe.call_far ? `CRF_CALL_FAR : `CRF_CALL_NEAR;
          end else if (start_pop) begin
            state <= CRF_ST_POP;
            kind <= exe.ret ? CRF_K_CALL : CRF_K_IRQ;
            cnt <= exe.ret ? (exe.ret_far ? `CRF_CALL_FAR : `CRF_CALL_NEAR)
                             - 4'd1 : `CRF_IRQ_BYTES - 4'd1;
          end
        end
        CRF_ST_PUSH: begin
          cnt <= cnt + 4'd1;
          if (push_done) begin
            state <= CRF_ST_IDLE;
          end
        end
        CRF_ST_POP: begin
          cnt <= cnt - 4'd1;
          if (cnt == 4'd0) begin
            state <= CRF_ST_IDLE;
          end
        end
      endcase
    end
  end

  // jump destination held while the return address is stacked
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      target <= 24'h000000;
    end else if (start_irq) begin
      target <= exe.vector;
    end else if (start_call) begin
      target <= exe.target;
    end
  end

  // stack port: push writes at sp, pop reads at sp+1 in the same cycle
  always_comb begin
    stk.wr = (state == CRF_ST_PUSH);
    stk.rd = pop_now;
    stk.addr = pop_now ? sp + 16'h0001 : sp;
    stk.wdata = ctx_byte(cnt, view);
  end

  // stack pointer; no guard against running below the stack area
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sp <= sp_fix(16'h0000) | (SP_RST & ~SP_FORCE_MASK);
    end else if (dwr && dbg.addr == `CRF_OFF_SPH) begin
      sp <= sp_fix({dbg.wdata, sp[7:0]});
    end else if (dwr && dbg.addr == `CRF_OFF_SPL) begin
      sp <= sp_fix({sp[15:8], dbg.wdata});
    end else if (state == CRF_ST_PUSH) begin
      sp <= sp_fix(sp - 16'h0001);
    end else if (pop_now) begin
      sp <= sp_fix(sp + 16'h0001);
    end
  end

  // accumulator
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc <= `CRF_DATA_RST;
    end else if (dwr && dbg.addr == `CRF_OFF_ACC) begin
      acc <= dbg.wdata;
    end else if (pop_now && cnt == 4'd7) begin
      acc <= stk_rdata;
    end else if (alu_go) begin
      unique case (exe.op)
        CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_SBC, CRF_OP_INC,
        CRF_OP_DEC, CRF_OP_NEG: acc <= alu[7:0];
        CRF_OP_LOGIC, CRF_OP_LOAD, CRF_OP_SHIFT: acc <= exe.opnd;
        default: acc <= acc;
      endcase
    end
  end

  // operand shaping for the flag arithmetic
  always_comb begin
    unique case (exe.op)
      CRF_OP_ADD: alu = alu8(acc, exe.opnd, 1'b0, 1'b0);
      CRF_OP_ADC: alu = alu8(acc, exe.opnd, cc[`CRF_CC_C], 1'b0);
      CRF_OP_SBC: alu = alu8(acc, exe.opnd, cc[`CRF_CC_C], 1'b1);
      CRF_OP_INC: alu = alu8(acc, 8'h01, 1'b0, 1'b0);
      CRF_OP_DEC: alu = alu8(acc, 8'h01, 1'b0, 1'b1);
      CRF_OP_NEG: alu = alu8(8'h00, acc, 1'b0, 1'b1);
      default: alu = alu8(acc, exe.opnd, 1'b0, 1'b1);
    endcase
  end

  // prefix applies to the instruction after it, cleared at its end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prefix_y <= 1'b0;
    end else if (exe.prefix) begin
      prefix_y <= 1'b1;
    end else if (exe.instr_end) begin
      prefix_y <= 1'b0;
    end
  end

  // first index register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      x <= 16'h0000;
    end else if (dwr && dbg.addr == `CRF_OFF_XH) begin
      x[15:8] <= dbg.wdata;
    end else if (dwr && dbg.addr == `CRF_OFF_XL) begin
      x[7:0] <= dbg.wdata;
    end else if (pop_now && cnt == 4'd6) begin
      x[15:8] <= stk_rdata;
    end else if (pop_now && cnt == 4'd5) begin
      x[7:0] <= stk_rdata;
    end else if (idle && exe.idx_wr && !prefix_y) begin
      x <= exe.idx_data;
    end
  end

  // second index register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      y <= 16'h0000;
    end else if (dwr && dbg.addr == `CRF_OFF_YH) begin
      y[15:8] <= dbg.wdata;
    end else if (dwr && dbg.addr == `CRF_OFF_YL) begin
      y[7:0] <= dbg.wdata;
    end else if (pop_now && cnt == 4'd4) begin
      y[15:8] <= stk_rdata;
    end else if (pop_now && cnt == 4'd3) begin
      y[7:0] <= stk_rdata;
    end else if (idle && exe.idx_wr && prefix_y) begin
      y <= exe.idx_data;
    end
  end

  // program counter; stacked jumps land when the last stack byte is written, fast interrupt entry jumps at once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc <= 24'h000000;
    end else if (dwr && dbg.addr == `CRF_OFF_PCE) begin
      pc[23:16] <= dbg.wdata;
    end else if (dwr && dbg.addr == `CRF_OFF_PCH) begin
      pc[15:8] <= dbg.wdata;
    end else if (dwr && dbg.addr == `CRF_OFF_PCL) begin
      pc[7:0] <= dbg.wdata;
    end else if (pop_now && cnt == 4'd2) begin
      pc[23:16] <= stk_rdata;
    end else if (pop_now && cnt == 4'd1) begin
      pc[15:8] <= stk_rdata;
    end else if (pop_now && cnt == 4'd0) begin
      pc[7:0] <= stk_rdata;
    end else if (push_done && kind != CRF_K_WFI) begin
      pc <= target;
    end else if (skip_irq) begin
      pc <= exe.vector;
    end else if (idle && exe.instr_end) begin
      pc <= exe.pc_next;
    end
  end

  // condition flags; bit 6 never stores a one
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cc <= `CRF_CC_RST;
    end else if (dwr && dbg.addr == `CRF_OFF_CC) begin
      cc <= dbg.wdata & `CRF_CC_MASK;
    end else if (pop_now && cnt == 4'd8) begin
      cc <= stk_rdata & `CRF_CC_MASK;
    end else if ((push_done && kind == CRF_K_IRQ) || skip_irq) begin
      cc[`CRF_CC_I1] <= 1'b1;
      cc[`CRF_CC_I0] <= 1'b1;
    end else if (alu_go) begin
      unique case (exe.op)
        CRF_OP_ADD, CRF_OP_ADC: begin
          cc[`CRF_CC_H] <= alu[9];
          cc[`CRF_CC_C] <= alu[10];
          cc[`CRF_CC_V] <= alu[8];
          cc[`CRF_CC_N] <= alu[7];
          cc[`CRF_CC_Z] <= (alu[7:0] == 8'h00);
        end
        CRF_OP_SUB, CRF_OP_SBC, CRF_OP_CP, CRF_OP_NEG: begin
          cc[`CRF_CC_C] <= alu[10];
          cc[`CRF_CC_V] <= alu[8];
          cc[`CRF_CC_N] <= alu[7];
          cc[`CRF_CC_Z] <= (alu[7:0] == 8'h00);
        end
        CRF_OP_INC, CRF_OP_DEC: begin
          cc[`CRF_CC_V] <= alu[8];
          cc[`CRF_CC_N] <= alu[7];
          cc[`CRF_CC_Z] <= (alu[7:0] == 8'h00);
        end
        CRF_OP_LOGIC, CRF_OP_LOAD: begin
          cc[`CRF_CC_N] <= exe.opnd[7];
          cc[`CRF_CC_Z] <= (exe.opnd == 8'h00);
        end
        CRF_OP_SHIFT: begin
          cc[`CRF_CC_C] <= exe.aux;
          cc[`CRF_CC_N] <= exe.opnd[7];
          cc[`CRF_CC_Z] <= (exe.opnd == 8'h00);
        end
        CRF_OP_BTJ: cc[`CRF_CC_C] <= exe.aux;
        CRF_OP_DIV: cc[`CRF_CC_C] <= exe.aux;
        CRF_OP_SCF: cc[`CRF_CC_C] <= 1'b1;
        CRF_OP_RCF: cc[`CRF_CC_C] <= 1'b0;
        CRF_OP_CCF: cc[`CRF_CC_C] <= ~cc[`CRF_CC_C];
        CRF_OP_SIM: begin
          cc[`CRF_CC_I1] <= 1'b1; // non-interruptible
          cc[`CRF_CC_I0] <= 1'b1;
        end
        CRF_OP_RIM: begin
          cc[`CRF_CC_I1] <= 1'b1; // main level
          cc[`CRF_CC_I0] <= 1'b0;
        end
        default: cc <= cc;
      endcase
    end
  end

  // early-saved context and sleep state around wait, halt and return
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctx_saved <= 1'b0;
      sleeping <= 1'b0;
    end else if (push_done && kind == CRF_K_WFI) begin
      ctx_saved <= 1'b1;
      sleeping <= 1'b1;
    end else if (skip_irq || start_irq) begin
      sleeping <= 1'b0;
    end else if (sleep_interrupt_return_op) begin
      sleeping <= 1'b1; // context stays stacked
    end else if (start_pop && exe.interrupt_return_op) begin
      ctx_saved <= 1'b0;
    end
  end

  // global configuration; reserved bits never store
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gcr <= `CRF_GCR_RST;
    end else if (cfg.sel && cfg.wr && cfg.addr == `CRF_OFF_GCR) begin
      gcr <= cfg.wdata & `CRF_GCR_MASK;
    end
  end

  // pin ownership: debug link until the disable bit is set
  assign link_en = !gcr[`CRF_GCR_SWD];
  assign pin_gpio = gcr[`CRF_GCR_SWD];
  assign cfg_rdata = (cfg.addr == `CRF_OFF_GCR) ? gcr : 8'h00;

  // debug read map; unmapped offsets read zero
  always_comb begin
    unique case (dbg.addr)
      `CRF_OFF_ACC: dbg_rdata = acc;
      `CRF_OFF_PCE: dbg_rdata = pc[23:16];
      `CRF_OFF_PCH: dbg_rdata = pc[15:8];
      `CRF_OFF_PCL: dbg_rdata = pc[7:0];
      `CRF_OFF_XH: dbg_rdata = x[15:8];
      `CRF_OFF_XL: dbg_rdata = x[7:0];
      `CRF_OFF_YH: dbg_rdata = y[15:8];
      `CRF_OFF_YL: dbg_rdata = y[7:0];
      `CRF_OFF_SPH: dbg_rdata = sp[15:8];
      `CRF_OFF_SPL: dbg_rdata = sp[7:0];
      `CRF_OFF_CC: dbg_rdata = cc;
      default: dbg_rdata = 8'h00;
    endcase
  end

  sequence s_nine_pushes;
    stk.wr [*8] ##1 stk.wr ##1 !stk.wr;
  endsequence

  sequence s_slot_zero_first;
    (stk.wdata == pc[7:0]) ##1 (stk.wdata == pc[15:8]);
  endsequence

  a_irq_nine_bytes: assert property (@(posedge clock) disable iff (!nrst)
    start_irq |=> s_nine_pushes)
    else $error("interrupt entry did not push nine bytes");

  a_push_order: assert property (@(posedge clock) disable iff (!nrst)
    (start_irq || start_call) |=> s_slot_zero_first)
    else $error("stack push order wrong");

  a_sp_push_dec: assert property (@(posedge clock) disable iff (!nrst)
    (stk.wr && !dwr) |=> sp == sp_fix($past(sp) - 16'h0001))
    else $error("stack pointer not decremented after push");

  a_pop_cc_first: assert property (@(posedge clock) disable iff (!nrst)
    (start_pop && exe.interrupt_return_op) |=> (stk.rd && cnt == 4'd8) [*1] ##8 stk.rd
    ##1 !stk.rd)
    else $error("interrupt return pop length wrong");

  a_cc_reserved: assert property (@(posedge clock) disable iff (!nrst)
    cc[`CRF_CC_RSV] == 1'b0)
    else $error("reserved flag bit set");

  a_mask_entry: assert property (@(posedge clock) disable iff (!nrst)
    (skip_irq && !dwr) |=> cc[`CRF_CC_I1] && cc[`CRF_CC_I0] &&
    pc == $past(exe.vector))
    else $error("interrupt entry did not mask or jump");

  a_half_carry: assert property (@(posedge clock) disable iff (!nrst)
    (alu_go && exe.op == CRF_OP_ADD && !dwr) |=> cc[`CRF_CC_H] ==
    (({1'b0, $past(acc[3:0])} + {1'b0, $past(exe.opnd[3:0])}) > 5'h0f))
    else $error("half carry wrong");

  a_zero_flag: assert property (@(posedge clock) disable iff (!nrst)
    (alu_go && exe.op == CRF_OP_LOGIC && !dwr) |=>
    cc[`CRF_CC_Z] == ($past(exe.opnd) == 8'h00) && acc == $past(exe.opnd))
    else $error("zero flag or result wrong");

  a_al_sleep: assert property (@(posedge clock) disable iff (!nrst)
    sleep_interrupt_return_op |=> sleeping && !stk.rd ##1 !stk.rd)
    else $error("return with activation bit set restored context");

  a_gcr_reserved: assert property (@(posedge clock) disable iff (!nrst)
    gcr[7:2] == 6'h00 && link_en != pin_gpio)
    else $error("configuration reserved bits or pin ownership wrong");

endmodule : crf_core

// >>> dv/crf_stack_model.sv
`timescale 1ns/10ps
module crf_stack_model (
  input wire logic clock,
  input wire crf_pkg::crf_stack_t stk,
  output logic [7:0] stk_rdata
);
  import crf_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] idle_pat = 8'ha5;

  // byte lands on the edge where the core presents it
  always @(posedge clock) begin
    if (stk.wr) begin
      mem[stk.addr] <= stk.wdata;
    end
    idle_pat <= ~idle_pat;
  end

  // async read; a toggling pattern when idle so stray samples show up
  assign stk_rdata = stk.rd ? mem[stk.addr] : idle_pat;
endmodule : crf_stack_model

// >>> dv/tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  import crf_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  crf_acc_req_t dbg = '0;
  crf_acc_req_t cfg = '0;
  crf_exec_t exe = '0;
  crf_stack_t stk;
  crf_view_t view;
  logic [7:0] stk_rdata;
  logic [7:0] dbg_rdata;
  logic [7:0] cfg_rdata;
  logic busy;
  logic sleeping;
  logic ctx_saved;
  logic link_en;
  logic pin_gpio;
  int error_cnt = 0;
  int compares = 0;
  // expected push slots: pc low..high, y, x, acc, flags
  logic [7:0] ord [9] = '{8'h23, 8'h22, 8'h21, 8'h27, 8'h26, 8'h25,
    8'h24, 8'h20, 8'h07};

  crf_core i_crf_core (.clock(clock), .nrst(nrst), .dbg(dbg),
    .dbg_rdata(dbg_rdata), .cfg(cfg), .cfg_rdata(cfg_rdata), .exe(exe),
    .stk(stk), .stk_rdata(stk_rdata), .view(view), .busy(busy),
    .sleeping(sleeping), .ctx_saved(ctx_saved), .link_en(link_en),
    .pin_gpio(pin_gpio));

  crf_stack_model i_crf_stack_model (.clock(clock), .stk(stk),
    .stk_rdata(stk_rdata));

  // free-running core clock
  always #5 clock = ~clock;

  task automatic wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  // leaves the write up; caller drops it once, avoiding double drives
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    dbg = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
    tick();
  endtask : dwr

  // bounded wait, returns how many cycles busy stood
  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      tick();
      n++;
    end
  endtask : wait_idle

  task automatic t_reset;
    `CHK("cc", 8'h28, view.cc)
    `CHK("link", 2'b10, {link_en, pin_gpio})
    `CHK("gcr", 8'h00, cfg_rdata)
  endtask : t_reset

  task automatic t_debug;
    for (int i = 0; i < 11; i++) begin
      dwr(i[7:0], (i == 10) ? 8'h47 : 8'h20 + i[7:0]);
    end
    dbg = '0;
    for (int i = 0; i < 12; i++) begin
      dbg.sel = 1'b1;
      dbg.addr = i[7:0];
      #1;
      `CHK("rd", (i > 10) ? 8'h00 : (i == 10) ? 8'h07 : 8'h20 + i[7:0],
        dbg_rdata)
      if (i == 0) `CHK("acc", 8'h20, dbg_rdata)
    end
    dbg = '0;
    `CHK("pc", 24'h212223, view.pc)
    `CHK("x", 16'h2425, view.x)
    `CHK("y", 16'h2627, view.y)
    `CHK("sp", 16'h2829, view.sp)
    `CHK("cc", 8'h07, view.cc)
  endtask : t_debug

  task automatic t_irq;
    int n;
    exe.irq = 1'b1;
    exe.vector = 24'h0abcde;
    tick();
    exe = '0;
    wait_idle(n);
    `CHK("push n", 9, n)
    `CHK("vec", 24'h0abcde, view.pc)
    `CHK("mask", 2'b11, {view.cc[5], view.cc[3]})
    `CHK("sp", 16'h2820, view.sp)
    for (int k = 0; k < 9; k++) begin
      `CHK("slot", ord[k], i_crf_stack_model.mem[16'h2829 - k])
    end
    dwr(8'h00, 8'h99);
    dbg = '0;
    exe.interrupt_return_op = 1'b1;
    tick();
    exe = '0;
    wait_idle(n);
    `CHK("pop n", 9, n)
    `CHK("acc", 8'h20, view.acc)
    `CHK("pc", 24'h212223, view.pc)
    `CHK("sp", 16'h2829, view.sp)
    `CHK("cc", 8'h07, view.cc)
  endtask : t_irq

  // flags packed as {v,h,n,z,c}
  task automatic t_add;
    dwr(8'h00, 8'hb5);
    dbg = '0;
    exe.op = CRF_OP_ADD;
    exe.opnd = 8'h94;
    tick();
    `CHK("sum", 8'h49, view.acc)
    `CHK("flg", 5'b10001, {view.cc[7], view.cc[4], view.cc[2:0]})
    exe.opnd = 8'hb7;
    tick();
    exe = '0;
    `CHK("sum0", 8'h00, view.acc)
    `CHK("flg0", 5'b01011, {view.cc[7], view.cc[4], view.cc[2:0]})
  endtask : t_add

  // prefix, call/return, subtract, early context save
  task automatic t_flow;
    int n;
    exe.prefix = 1'b1;
    tick();
    exe = '0;
    exe.idx_wr = 1'b1;
    exe.idx_data = 16'h1357;
    exe.instr_end = 1'b1;
    exe.pc_next = 24'h000100;
    tick();
    exe = '0;
    `CHK("y pre", 16'h1357, view.y)
    `CHK("x kept", 16'h2425, view.x)
    `CHK("pc nxt", 24'h000100, view.pc)
    exe.idx_wr = 1'b1;
    exe.idx_data = 16'h2468;
    tick();
    exe = '0;
    `CHK("x wr", 16'h2468, view.x)
    exe.call = 1'b1;
    exe.target = 24'h004000;
    tick();
    exe = '0;
    wait_idle(n);
    `CHK("call n", 2, n)
    `CHK("call pc", 24'h004000, view.pc)
    `CHK("call sp", 16'h2827, view.sp)
    `CHK("ret lo", 8'h00, i_crf_stack_model.mem[16'h2829])
    `CHK("ret hi", 8'h01, i_crf_stack_model.mem[16'h2828])
    exe.ret = 1'b1;
    tick();
    exe = '0;
    wait_idle(n);
    `CHK("ret n", 2, n)
    `CHK("ret pc", 24'h000100, view.pc)
    `CHK("ret sp", 16'h2829, view.sp)
    exe.op = CRF_OP_SUB;
    exe.opnd = 8'h21;
    tick();
    exe = '0;
    `CHK("diff", 8'hff, view.acc)
    `CHK("sflg", 4'b0101, {view.cc[7], view.cc[2:0]})
    exe.wait_for_interrupt_op = 1'b1;
    tick();
    exe = '0;
    wait_idle(n);
    `CHK("wfi n", 9, n)
    `CHK("wfi st", 2'b11, {sleeping, ctx_saved})
    `CHK("wfi sp", 16'h2820, view.sp)
    exe.irq = 1'b1;
    exe.vector = 24'h0055aa;
    tick();
    exe = '0;
    `CHK("fast", 2'b00, {busy, sleeping})
    `CHK("fast pc", 24'h0055aa, view.pc)
    `CHK("fast msk", 2'b11, {view.cc[5], view.cc[3]})
    exe.interrupt_return_op = 1'b1;
    tick();
    exe = '0;
    wait_idle(n);
    `CHK("interrupt_return_op n", 9, n)
    `CHK("interrupt_return_op pc", 24'h000100, view.pc)
    `CHK("interrupt_return_op acc", 8'hff, view.acc)
    `CHK("interrupt_return_op cc", 8'h05, view.cc)
    `CHK("interrupt_return_op ctx", 1'b0, ctx_saved)
  endtask : t_flow

  task automatic t_cfg;
    cfg = '{sel: 1'b1, wr: 1'b1, addr: 8'h00, wdata: 8'hff};
    tick();
    cfg.wdata = 8'h02;
    `CHK("gcr", 8'h03, cfg_rdata)
    `CHK("link", 2'b01, {link_en, pin_gpio})
    tick();
    cfg = '0;
    exe.interrupt_return_op = 1'b1;
    tick();
    exe = '0;
    #1;
    `CHK("sleep", 2'b01, {busy, sleeping})
    `CHK("sp", 16'h2829, view.sp)
  endtask : t_cfg

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_reset();
    t_debug();
    t_add();
    t_debug();
    t_irq();
    t_flow();
    t_cfg();
    wrap_up();
  end

  // watchdog well past the roughly 90 cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule : tb
